//--- design/tcw_cfg.svh
// Contract
// RQ1: Host writes zero to reserved command bits.
// RQ2: Start offset bits 20:16, zero to 31.
// RQ3: Bit 13 marks first segment of packet.
// RQ4: Bit 12 marks last segment of packet.
// RQ5: Size bits 10:0 with alignment drop padding.
// RQ6: Keep running byte sum over packet segments.
// RQ7: Sum differs from length: raise error flag.
// RQ8: Alignment codes 00=4, 01=16, 10=32 bytes.
// RQ9: Host pads to boundary; device strips it.
// RQ10: Packet length from second word bits 10:0.
// RQ11: Offset low bits select first byte lane.
// RQ12: Host keeps middle buffers at least 4 bytes.
`ifndef TCW_CFG_SVH
`define TCW_CFG_SVH
`define TCW_ALIGN_HI   25
`define TCW_ALIGN_LO   24
`define TCW_OFF_HI     20
`define TCW_OFF_LO     16
`define TCW_FS_BIT     13
`define TCW_LS_BIT     12
`define TCW_SIZE_HI    10
`define TCW_SIZE_LO    0
`define TCW_LEN_HI     10
`define TCW_LEN_LO     0
`define TCW_AL_4       2'h0
`define TCW_AL_16      2'h1
`define TCW_AL_32      2'h2
`define TCW_MASK_4     12'h003
`define TCW_MASK_16    12'h00f
`define TCW_MASK_32    12'h01f
`define TCW_DW_SHIFT   2
`define TCW_ONE_12     12'h001
`define TCW_ONE_10     10'h001
`define TCW_ZERO_12    12'h000
`define TCW_ZERO_10    10'h000
`define TCW_BE_NONE    4'h0
`define TCW_DATA_ZERO  32'h0000_0000
`endif

//--- design/tcw_pkg.sv
package tcw_pkg;
    typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_DATA} tcw_state_e;
    typedef logic [11:0] tcw_bytes_t;
    typedef logic [9:0]  tcw_dw_t;
endpackage : tcw_pkg

//--- design/tcw_cmd_if.sv
`timescale 1ns/100ps
interface tcw_cmd_if;
    logic [31:0] word;
    logic [1:0]  align;
    logic [4:0]  off;
    logic        fs;
    logic        ls;
    logic [10:0] size;
    logic [10:0] len;
    modport dec (input word, output align, off, fs, ls, size, len);
    modport use_side (output word, input align, off, fs, ls, size, len);
endinterface : tcw_cmd_if

//--- design/tcw_cmd_decode.sv
`timescale 1ns/100ps
`include "tcw_cfg.svh"
module tcw_cmd_decode (
    tcw_cmd_if.dec cmd
);
    // Reserved bits are not looked at; host keeps them zero [RQ1]
    assign cmd.align = cmd.word[`TCW_ALIGN_HI:`TCW_ALIGN_LO];   // [RQ8]
    assign cmd.off   = cmd.word[`TCW_OFF_HI:`TCW_OFF_LO];       // [RQ2]
    assign cmd.fs    = cmd.word[`TCW_FS_BIT];                   // [RQ3]
    assign cmd.ls    = cmd.word[`TCW_LS_BIT];                   // [RQ4]
    assign cmd.size  = cmd.word[`TCW_SIZE_HI:`TCW_SIZE_LO];     // [RQ5]
    assign cmd.len   = cmd.word[`TCW_LEN_HI:`TCW_LEN_LO];       // [RQ10]
endmodule : tcw_cmd_decode

//--- design/tcw_parser.sv
`timescale 1ns/100ps
`include "tcw_cfg.svh"
module tcw_parser
    import tcw_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        IN_VALID,
    input  wire logic [31:0] IN_DATA,
    input  wire logic        ERR_CLR,
    output logic             OUT_VALID,
    output logic [31:0]      OUT_DATA,
    output logic [3:0]       OUT_BE,
    output logic             OUT_SOP,
    output logic             OUT_EOP,
    output logic             TX_ERR,
    output logic [11:0]      PKT_SUM
);
    tcw_cmd_if cmd ();
    tcw_cmd_decode u_dec (.cmd(cmd));
    assign cmd.word = IN_DATA;

    tcw_state_e  state_ff, nxt_state;
    logic        fs_ff, nxt_fs, ls_ff, nxt_ls, sop_pend_ff, nxt_sop_pend;
    logic [4:0]  off_ff, nxt_off;
    tcw_bytes_t  end_ff, nxt_end, sum_ff, nxt_sum;
    tcw_dw_t     total_ff, nxt_total, last_ff, nxt_last, idx_ff, nxt_idx;
    logic        err_ff, nxt_err, ov_ff, nxt_ov, sop_ff, nxt_sop;
    logic        eop_ff, nxt_eop;
    logic [31:0] od_ff, nxt_od;
    logic [3:0]  be_ff, nxt_be, cur_be;
    tcw_bytes_t  a_end, a_pad, a_mask;
    logic        mismatch;

    // Lane b of dword idx is live when off <= idx*4+b < end
    function automatic logic [3:0] lane_en(tcw_dw_t idx, logic [4:0] off,
                                           tcw_bytes_t fin);
        tcw_bytes_t pos;
        lane_en = `TCW_BE_NONE;
        for (int b = 0; b < 4; b++) begin
            pos = {idx, 2'(b)};
            lane_en[b] = (pos >= {7'h00, off}) && (pos < fin);
        end
    endfunction : lane_en

    function automatic tcw_bytes_t align_mask(logic [1:0] code);
        unique case (code)
            `TCW_AL_16: align_mask = `TCW_MASK_16;   // [RQ8]
            `TCW_AL_32: align_mask = `TCW_MASK_32;   // [RQ8]
            default:    align_mask = `TCW_MASK_4;    // Reserved code as 4-byte
        endcase
    endfunction : align_mask

    always_comb begin
        a_end    = {7'h00, cmd.off} + {1'b0, cmd.size};
        a_mask   = align_mask(cmd.align);
        a_pad    = (a_end + a_mask) & ~a_mask;                  // [RQ9]
        cur_be   = lane_en(idx_ff, off_ff, end_ff);             // [RQ11]
        mismatch = sum_ff != {1'b0, cmd.len};                   // [RQ10]
    end

    always_comb begin
        nxt_state    = state_ff;
        nxt_fs       = fs_ff;
        nxt_ls       = ls_ff;
        nxt_sop_pend = sop_pend_ff;
        nxt_off      = off_ff;
        nxt_end      = end_ff;
        nxt_sum      = sum_ff;
        nxt_total    = total_ff;
        nxt_last     = last_ff;
        nxt_idx      = idx_ff;
        nxt_ov       = 1'b0;
        nxt_sop      = 1'b0;
        nxt_eop      = 1'b0;
        nxt_od       = od_ff;
        nxt_be       = be_ff;
        // Set beats clear so a mismatch in the clearing cycle is kept
        nxt_err      = err_ff & ~ERR_CLR;
        unique case (state_ff)
            ST_CMD_A: if (IN_VALID) begin
                nxt_fs    = cmd.fs;                              // [RQ3]
                nxt_ls    = cmd.ls;                              // [RQ4]
                nxt_off   = cmd.off;                             // [RQ2]
                nxt_end   = a_end;
                nxt_total = a_pad[11:`TCW_DW_SHIFT];             // [RQ5]
                nxt_last  = 10'((a_end - `TCW_ONE_12) >> `TCW_DW_SHIFT);
                nxt_sum   = cmd.fs ? {1'b0, cmd.size}
                                   : sum_ff + {1'b0, cmd.size};  // [RQ6]
                // Cleared too, so no stale start lands on a later buffer
                nxt_sop_pend = cmd.fs;                           // [RQ3]
                nxt_state = ST_CMD_B;
            end
            ST_CMD_B: if (IN_VALID) begin
                if (ls_ff && mismatch) begin
                    nxt_err = 1'b1;                              // [RQ7]
                end
                nxt_idx   = `TCW_ZERO_10;
                nxt_state = (total_ff == `TCW_ZERO_10) ? ST_CMD_A : ST_DATA;
            end
            ST_DATA: if (IN_VALID) begin
                // Offset and padding dwords are consumed, never sent
                if (cur_be != `TCW_BE_NONE) begin               // [RQ5] [RQ9]
                    nxt_ov       = 1'b1;
                    nxt_od       = IN_DATA;
                    nxt_be       = cur_be;                       // [RQ11]
                    nxt_sop      = sop_pend_ff;
                    nxt_sop_pend = 1'b0;
                    nxt_eop      = ls_ff && (idx_ff == last_ff); // [RQ4]
                end
                nxt_idx = idx_ff + `TCW_ONE_10;
                if (idx_ff == total_ff - `TCW_ONE_10) begin
                    nxt_state = ST_CMD_A;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff    <= ST_CMD_A;
            fs_ff       <= 1'b0;
            ls_ff       <= 1'b0;
            sop_pend_ff <= 1'b0;
            off_ff      <= 5'h00;
            end_ff      <= `TCW_ZERO_12;
            sum_ff      <= `TCW_ZERO_12;
            total_ff    <= `TCW_ZERO_10;
            last_ff     <= `TCW_ZERO_10;
            idx_ff      <= `TCW_ZERO_10;
            err_ff      <= 1'b0;
            ov_ff       <= 1'b0;
            sop_ff      <= 1'b0;
            eop_ff      <= 1'b0;
            od_ff       <= `TCW_DATA_ZERO;
            be_ff       <= `TCW_BE_NONE;
        end else begin
            state_ff    <= nxt_state;
            fs_ff       <= nxt_fs;
            ls_ff       <= nxt_ls;
            sop_pend_ff <= nxt_sop_pend;
            off_ff      <= nxt_off;
            end_ff      <= nxt_end;
            sum_ff      <= nxt_sum;
            total_ff    <= nxt_total;
            last_ff     <= nxt_last;
            idx_ff      <= nxt_idx;
            err_ff      <= nxt_err;
            ov_ff       <= nxt_ov;
            sop_ff      <= nxt_sop;
            eop_ff      <= nxt_eop;
            od_ff       <= nxt_od;
            be_ff       <= nxt_be;
        end
    end

    assign OUT_VALID = ov_ff;
    assign OUT_DATA  = od_ff;
    assign OUT_BE    = be_ff;
    assign OUT_SOP   = sop_ff;
    assign OUT_EOP   = eop_ff;
    assign TX_ERR    = err_ff;
    assign PKT_SUM   = sum_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic a_take, b_take, d_take;
    assign a_take = state_ff == ST_CMD_A && IN_VALID;
    assign b_take = state_ff == ST_CMD_B && IN_VALID;
    assign d_take = state_ff == ST_DATA && IN_VALID;

    sum_first_a: assert property (a_take && cmd.fs |=> // [RQ3]
        PKT_SUM == {1'b0, $past(cmd.size)})
        else $error("Sum not restarted on first segment");
    sum_acc_a: assert property (a_take && !cmd.fs |=> // [RQ6]
        PKT_SUM == $past(sum_ff) + {1'b0, $past(cmd.size)})
        else $error("Sum not accumulated");
    err_set_a: assert property (b_take && ls_ff && mismatch |=> TX_ERR) // [RQ7]
        else $error("Length mismatch not flagged");
    err_quiet_a: assert property (!TX_ERR && !(b_take && ls_ff && mismatch)
        |=> !TX_ERR) // [RQ7]
        else $error("Error flag raised without cause");
    // Clear with no new mismatch must drop the flag
    err_clear_a: assert property (TX_ERR && ERR_CLR && // [RQ7]
        !(b_take && ls_ff && mismatch) |=> !TX_ERR)
        else $error("Error flag not cleared");
    pad_drop_a: assert property (d_take && cur_be == 4'h0 |=> // [RQ9]
        !OUT_VALID)
        else $error("Padding dword forwarded");
    off_skip_a: assert property (d_take && idx_ff < 10'(off_ff >> 2) |=> // [RQ2]
        !OUT_VALID)
        else $error("Offset dword forwarded");
    sop_lane_a: assert property (OUT_SOP |-> // [RQ11]
        OUT_BE[off_ff[1:0]] && (OUT_BE & ((4'h1 << off_ff[1:0]) - 4'h1)) == 4'h0)
        else $error("First byte lane wrong");
    align16_a: assert property (a_take && cmd.align == 2'h1 |=> // [RQ8]
        total_ff[1:0] == 2'h0)
        else $error("16-byte alignment not kept");
    align32_a: assert property (a_take && cmd.align == 2'h2 |=> // [RQ8]
        total_ff[2:0] == 3'h0)
        else $error("32-byte alignment not kept");
    data_len_a: assert property (state_ff == ST_DATA |-> // [RQ5]
        idx_ff < total_ff)
        else $error("Data phase overran buffer");
    eop_last_a: assert property (OUT_EOP |-> OUT_VALID && ls_ff) // [RQ4]
        else $error("End of packet outside last segment");

    single_c: cover property (a_take && cmd.fs && cmd.ls ##1 b_take);
    multi_c:  cover property (a_take && !cmd.fs && cmd.ls);
    err_c:    cover property (b_take && ls_ff && mismatch);
    pad_c:    cover property (d_take && cur_be == 4'h0 && idx_ff > last_ff);
    sop_c:    cover property (OUT_SOP && OUT_EOP);
endmodule : tcw_parser

//--- tb/tcw_host_model.sv
`timescale 1ns/100ps
module tcw_host_model (
    input  wire logic        CLK,
    output logic             IN_VALID,
    output logic [31:0]      IN_DATA
);
    initial IN_VALID = 1'b0;
    initial IN_DATA = 32'h0;
    // Idle data is flipped so a stale word never looks valid
    task put(input logic [31:0] d, input bit gap);
        if (gap) begin
            @(posedge CLK);
            IN_VALID <= 1'b0;
            IN_DATA  <= ~IN_DATA;
        end
        @(posedge CLK);
        IN_VALID <= 1'b1;
        IN_DATA  <= d;
    endtask : put
    // Reserved bits left zero pads to boundary
    task send(input logic [1:0] al, input logic [4:0] off,
              input logic [10:0] sz, input bit fs, input bit ls,
              input logic [10:0] len, input bit gap);
        int a;
        int n;
        a = (al == 2'h1) ? 16 : (al == 2'h2) ? 32 : 4;
        n = (int'(off) + int'(sz) + a - 1) / a * a / 4;
        put({6'h0, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz}, gap);
        put({21'h0, len}, gap);
        for (int i = 0; i < n; i++) put(32'h5a00_0000 | i, gap);
        @(posedge CLK);
        IN_VALID <= 1'b0;
        IN_DATA  <= ~IN_DATA;
    endtask : send
endmodule : tcw_host_model

//--- tb/test_tcw_parser.sv
`timescale 1ns/100ps
module test_tcw_parser;
    typedef struct packed {
        logic [1:0]  al;
        logic [4:0]  off;
        logic [10:0] sz;
        logic        fs;
        logic        ls;
        logic [10:0] len;
        // Expected sum and error flag after the buffer
        logic [11:0] xs;
        logic        xe;
    } tcw_row_s;
    logic        CLK, RST_N, ERR_CLR, IN_VALID, OUT_VALID;
    logic        OUT_SOP, OUT_EOP, TX_ERR;
    logic [31:0] IN_DATA, OUT_DATA;
    logic [3:0]  OUT_BE;
    logic [11:0] PKT_SUM;
    logic [37:0] exp_q[$];
    logic [37:0] e;
    int          n_mismatch, checked;
    tcw_row_s    rows[9];

    tcw_parser dut (.CLK(CLK), .RST_N(RST_N), .IN_VALID(IN_VALID),
        .IN_DATA(IN_DATA), .ERR_CLR(ERR_CLR), .OUT_VALID(OUT_VALID),
        .OUT_DATA(OUT_DATA), .OUT_BE(OUT_BE), .OUT_SOP(OUT_SOP),
        .OUT_EOP(OUT_EOP), .TX_ERR(TX_ERR), .PKT_SUM(PKT_SUM));
    tcw_host_model host (.CLK(CLK), .IN_VALID(IN_VALID),
        .IN_DATA(IN_DATA));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task complete_run;
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    always @(negedge CLK) begin
        if (OUT_VALID === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 38'h0;
            check("data", OUT_DATA, e[37:6]);
            check("be", 32'(OUT_BE), 32'(e[5:2]));
            check("sop", 32'(OUT_SOP), 32'(e[1]));
            check("eop", 32'(OUT_EOP), 32'(e[0]));
        end
    end

    // Live lanes are off..off+sz-1; a dword with none gives no output
    task push(input tcw_row_s r);
        int         last;
        logic [3:0] be;
        last = (int'(r.off) + int'(r.sz) - 1) / 4;
        for (int d = 0; d <= last; d++) begin
            for (int b = 0; b < 4; b++) begin
                be[b] = (4 * d + b >= r.off) && (4 * d + b < r.off + r.sz);
            end
            if (be != 4'h0) exp_q.push_back({32'h5a00_0000 | d, be,
                r.fs && d == r.off / 4, r.ls && d == last});
        end
    endtask : push

    task run_row(input tcw_row_s r, input bit gap, input bit clr);
        push(r);
        host.send(r.al, r.off, r.sz, r.fs, r.ls, r.len, gap);
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        check("sum", 32'(PKT_SUM), 32'(r.xs));
        check("err", 32'(TX_ERR), 32'(r.xe));
        check("left", 32'(exp_q.size()), 32'h0);
        if (clr) begin
            @(posedge CLK) ERR_CLR <= 1'b1;
            @(posedge CLK) ERR_CLR <= 1'b0;
            @(negedge CLK);
            check("clr", 32'(TX_ERR), 32'h0);
        end
    endtask : run_row

    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        complete_run();
    end

    initial begin
        RST_N = 1'b0;
        ERR_CLR = 1'b0;
        n_mismatch = 0;
        checked = 0;
        rows = '{'{2'h0, 5'h01, 11'h005, 1'b1, 1'b1, 11'h005, 12'h005, 1'b0},
                 '{2'h1, 5'h03, 11'h014, 1'b1, 1'b1, 11'h014, 12'h014, 1'b0},
                 '{2'h2, 5'h1f, 11'h001, 1'b1, 1'b1, 11'h001, 12'h001, 1'b0},
                 '{2'h3, 5'h02, 11'h006, 1'b1, 1'b1, 11'h006, 12'h006, 1'b0},
                 '{2'h0, 5'h00, 11'h007, 1'b1, 1'b0, 11'h014, 12'h007, 1'b0},
                 // Middle buffer kept at 4 bytes
                 '{2'h1, 5'h05, 11'h004, 1'b0, 1'b0, 11'h014, 12'h00b, 1'b0},
                 '{2'h0, 5'h00, 11'h009, 1'b0, 1'b1, 11'h014, 12'h014, 1'b0},
                 '{2'h0, 5'h00, 11'h004, 1'b1, 1'b1, 11'h005, 12'h004, 1'b1},
                 '{2'h0, 5'h00, 11'h000, 1'b1, 1'b1, 11'h000, 12'h000, 1'b0}};
        repeat (5) @(posedge CLK);
        check("rst valid", 32'(OUT_VALID), 32'h0);
        RST_N <= 1'b1;
        foreach (rows[i]) run_row(rows[i], i[0], 1'b1);
        // Error left standing, then reset in mid-run
        run_row(rows[7], 1'b0, 1'b0);
        @(posedge CLK) RST_N <= 1'b0;
        #1;
        check("rst err", 32'(TX_ERR), 32'h0);
        check("rst sum", 32'(PKT_SUM), 32'h0);
        @(posedge CLK) RST_N <= 1'b1;
        run_row(rows[0], 1'b0, 1'b1);
        complete_run();
    end
endmodule : test_tcw_parser
